// File: aes_pkg.sv
// Constants for the auto-negotiation expansion status register
// What this block does
// - Reserved bits fifteen down to five read as zero.
// - Writes to reserved bits ignored unless command override bit is one.
// - Bit four latches high on a parallel detection fault.
// - Bit three reports partner's received next-page bit.
// - Bit two always reads one: local device supports next pages.
// - Bit one latches high when a new code word is stored.
// - Reading the register clears the page-received flag.
// - Bit zero is one while valid pulse bursts arrive from partner, one cycle late.
// - Partner ability is loaded from received code word, raising page-received.
package aes_pkg;
   localparam int          DATA_WIDTH       = 16;
   localparam int          ADDR_WIDTH       = 5;
   localparam logic [4:0]  EXP_STATUS_ADDR  = 5'h06;
   localparam int          BIT_PD_FAULT     = 4;
   localparam int          BIT_LP_NP_ABLE   = 3;
   localparam int          BIT_NP_ABLE      = 2;
   localparam int          BIT_PAGE_RX      = 1;
   localparam int          BIT_LP_AN_ABLE   = 0;
   localparam int          RSV_LO           = 5;
   localparam int          RSV_HI           = 15;
   localparam int          RSV_WIDTH        = 11;
   localparam logic [10:0] RSV_RESET        = 11'h000;
   localparam logic        RSV_BIT_RESET    = 1'h0;
   localparam logic        FLAG_RESET       = 1'h0;
   localparam logic        NP_ABLE_VALUE    = 1'h1;
   localparam logic [15:0] ABILITY_RESET    = 16'h0000;
   localparam logic [15:0] RDATA_RESET      = 16'h0000;
   localparam int          CODE_WORD_NP_BIT = 15;
endpackage

// File: aes_expansion_status.sv
// Auto-negotiation expansion status register with management access
`timescale 1ns/1ps
`default_nettype none
module aes_expansion_status #(
   // Register and field widths
   parameter int DATA_W = aes_pkg::DATA_WIDTH,
   parameter int ADDR_W = aes_pkg::ADDR_WIDTH,
   parameter int RSV_W  = aes_pkg::RSV_WIDTH
) (
   // Clock and reset
   input  wire logic              CLOCK_I,
   input  wire logic              RST_I,
   // Management access
   input  wire logic [ADDR_W-1:0] REG_ADDR_I,
   input  wire logic              REG_RD_I,
   input  wire logic              REG_WR_I,
   input  wire logic [DATA_W-1:0] REG_WDATA_I,
   input  wire logic              CMD_OVERRIDE_I,
   output logic      [DATA_W-1:0] REG_RDATA_O,
   // Negotiation events
   input  wire logic              PD_FAULT_I,
   input  wire logic              CODE_WORD_STORE_I,
   input  wire logic [DATA_W-1:0] CODE_WORD_I,
   input  wire logic              FLP_VALID_I,
   // Partner ability
   output logic      [DATA_W-1:0] PARTNER_ABILITY_O
);

   // ----------------------------------------
   // Constants
   // ----------------------------------------
   // Own address and reset words at the configured widths
   localparam logic [ADDR_W-1:0] OWN_ADDR      =
      ADDR_W'(aes_pkg::EXP_STATUS_ADDR);
   localparam logic [DATA_W-1:0] ABILITY_RESET =
      DATA_W'(aes_pkg::ABILITY_RESET);
   localparam logic [DATA_W-1:0] RDATA_RESET   =
      DATA_W'(aes_pkg::RDATA_RESET);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Address decode
   logic                  rd_hit;
   logic                  wr_hit;
   logic                  rsv_wr_en;
   // Latched status flags
   logic                  pd_fault;
   logic                  next_pd_fault;
   logic                  page_rx;
   logic                  next_page_rx;
   // Partner capabilities
   logic                  lp_np;
   logic                  next_lp_np;
   logic                  lp_an;
   logic                  next_lp_an;
   logic     [DATA_W-1:0] ability;
   logic     [DATA_W-1:0] next_ability;
   // Override-gated reserved storage, never shown on the read word
   wire logic [RSV_W-1:0] rsv;
   // Read word
   logic     [DATA_W-1:0] status_word;
   logic     [DATA_W-1:0] rdata;
   logic     [DATA_W-1:0] next_rdata;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Other addresses belong to neighbouring registers and are ignored
   // Writes reach only the reserved storage, and only under override
   always_comb begin
      rd_hit    = REG_RD_I && (REG_ADDR_I == OWN_ADDR);
      wr_hit    = REG_WR_I && (REG_ADDR_I == OWN_ADDR);
      rsv_wr_en = wr_hit && CMD_OVERRIDE_I;
   end

   // ----------------------------------------
   // Parallel detection fault flag
   // ----------------------------------------
   // The fault wins over a read clear in the same cycle, so none is lost
   always_comb begin
      next_pd_fault = pd_fault;
      if (rd_hit) begin
         next_pd_fault = 1'h0;
      end
      if (PD_FAULT_I) begin
         next_pd_fault = 1'h1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         pd_fault <= aes_pkg::FLAG_RESET;
      end else begin
         pd_fault <= next_pd_fault;
      end
   end

   // ----------------------------------------
   // Page received flag
   // ----------------------------------------
   // Storing a word into the ability register is the setting event
   // A new page wins over a read clear in the same cycle
   always_comb begin
      next_page_rx = page_rx;
      if (rd_hit) begin
         next_page_rx = 1'h0;
      end
      if (CODE_WORD_STORE_I) begin
         next_page_rx = 1'h1;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         page_rx <= aes_pkg::FLAG_RESET;
      end else begin
         page_rx <= next_page_rx;
      end
   end

   // ----------------------------------------
   // Partner capabilities from the stored code word
   // ----------------------------------------
   // The code word lines are only meaningful with the store pulse
   // Bit three changes only when a new word is stored
   always_comb begin
      next_ability = ability;
      next_lp_np   = lp_np;
      if (CODE_WORD_STORE_I) begin
         next_ability = CODE_WORD_I;
         next_lp_np   = CODE_WORD_I[aes_pkg::CODE_WORD_NP_BIT];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ability <= ABILITY_RESET;
         lp_np   <= aes_pkg::FLAG_RESET;
      end else begin
         ability <= next_ability;
         lp_np   <= next_lp_np;
      end
   end

   // ----------------------------------------
   // Partner auto-negotiation ability
   // ----------------------------------------
   // Follows the burst indication one cycle late; it is not latched
   always_comb begin
      next_lp_an = FLP_VALID_I;
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         lp_an <= aes_pkg::FLAG_RESET;
      end else begin
         lp_an <= next_lp_an;
      end
   end

   // ----------------------------------------
   // Override-gated reserved storage
   // ----------------------------------------
   // Writes without the override are dropped; the stored bits drive no
   // status and exist only so an override write behaves as a real write
   genvar g;
   generate
      for (g = 0; g < RSV_W; g = g + 1) begin : g_rsv
         logic stored;
         logic next_stored;

         always_comb begin
            next_stored = stored;
            if (rsv_wr_en) begin
               next_stored = REG_WDATA_I[aes_pkg::RSV_LO + g];
            end
         end

         always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
               stored <= aes_pkg::RSV_BIT_RESET;
            end else begin
               stored <= next_stored;
            end
         end

         assign rsv[g] = stored;
      end
   endgenerate

   // ----------------------------------------
   // Read word
   // ----------------------------------------
   // Latched bits are captured as they stand before the read clear
   // Reserved positions stay zero whatever the override has stored
   always_comb begin
      status_word                          = '0;
      status_word[aes_pkg::BIT_PD_FAULT]   = pd_fault;
      status_word[aes_pkg::BIT_LP_NP_ABLE] = lp_np;
      status_word[aes_pkg::BIT_NP_ABLE]    = aes_pkg::NP_ABLE_VALUE;
      status_word[aes_pkg::BIT_PAGE_RX]    = page_rx;
      status_word[aes_pkg::BIT_LP_AN_ABLE] = lp_an;
      next_rdata = rdata;
      if (rd_hit) begin
         next_rdata = status_word;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         rdata <= RDATA_RESET;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Both outputs come straight from their registers
   assign REG_RDATA_O       = rdata;
   assign PARTNER_ABILITY_O = ability;
endmodule
`default_nettype wire

// File: aes_expansion_status_assertions.sv
// Checker of read data and latch timing
`timescale 1ns/1ps
`default_nettype none
module aes_chk (
   // Clock and reset
   input wire logic        CLOCK_I,
   input wire logic        RST_I,
   // Management access
   input wire logic        REG_RD_I,
   input wire logic [4:0]  REG_ADDR_I,
   input wire logic [15:0] REG_RDATA_O,
   // Negotiation events
   input wire logic        PD_FAULT_I,
   input wire logic        CODE_WORD_STORE_I,
   input wire logic [15:0] CODE_WORD_I,
   input wire logic        FLP_VALID_I,
   // Partner ability
   input wire logic [15:0] PARTNER_ABILITY_O
);
   wire logic rd_own = REG_RD_I && REG_ADDR_I == aes_pkg::EXP_STATUS_ADDR;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   sequence quiet_rd;
      rd_own && !CODE_WORD_STORE_I ##1 !CODE_WORD_STORE_I;
   endsequence
   sequence quiet_pd;
      rd_own && !PD_FAULT_I ##1 !PD_FAULT_I;
   endsequence
   sequence store_then_rd;
      CODE_WORD_STORE_I ##1 rd_own;
   endsequence
   a_rsv_read_zero: assert property (
      rd_own |=> REG_RDATA_O[15:5] == '0)
      else $error("reserved bits set");
   a_np_able_one: assert property (
      rd_own |=> REG_RDATA_O[2])
      else $error("next page able low");
   a_page_rx_set: assert property (
      store_then_rd |=> REG_RDATA_O[1])
      else $error("page flag not set");
   a_page_rx_clear: assert property (
      quiet_rd ##1 rd_own |=> !REG_RDATA_O[1])
      else $error("page flag not cleared");
   a_ability_load: assert property (
      CODE_WORD_STORE_I |=> PARTNER_ABILITY_O == $past(CODE_WORD_I))
      else $error("ability not loaded");
   a_lp_np_copy: assert property (
      store_then_rd |=> REG_RDATA_O[3] == $past(CODE_WORD_I[15], 2))
      else $error("partner next page bit wrong");
   a_pd_fault_set: assert property (
      PD_FAULT_I ##1 rd_own |=> REG_RDATA_O[4])
      else $error("fault flag not set");
   a_pd_fault_clear: assert property (
      quiet_pd ##1 rd_own |=> !REG_RDATA_O[4])
      else $error("fault flag not cleared");
   a_lp_an_follow: assert property (
      FLP_VALID_I ##1 rd_own |=> REG_RDATA_O[0])
      else $error("partner negotiation bit low");
endmodule
bind aes_expansion_status aes_chk u_chk (
   .CLOCK_I           (CLOCK_I),
   .RST_I             (RST_I),
   .REG_RD_I          (REG_RD_I),
   .REG_ADDR_I        (REG_ADDR_I),
   .REG_RDATA_O       (REG_RDATA_O),
   .PD_FAULT_I        (PD_FAULT_I),
   .CODE_WORD_STORE_I (CODE_WORD_STORE_I),
   .CODE_WORD_I       (CODE_WORD_I),
   .FLP_VALID_I       (FLP_VALID_I),
   .PARTNER_ABILITY_O (PARTNER_ABILITY_O)
);
`default_nettype wire

// File: aes_partner.sv
// Link partner model delivering received code words
`timescale 1ns/1ps
`default_nettype none
module aes_partner (
   // Clock
   input  wire logic        clk_i,
   // Request from the bench
   input  wire logic        send_i,
   input  wire logic [15:0] word_i,
   // Toward the block
   output logic             store_o,
   output logic      [15:0] word_o
);
   // Word lines change while idle so a stale word cannot pass unseen
   always_ff @(posedge clk_i) begin
      store_o <= send_i;
      word_o  <= send_i ? word_i : ~word_o;
   end
endmodule
`default_nettype wire

// File: aes_expansion_status_bench.sv
// Bench for the expansion status register
`timescale 1ns/1ps
`default_nettype none
module aes_expansion_status_bench;
   logic c = 0, r = 1, rd = 0, wr = 0, ov = 0, pd = 0, fl = 0, sn = 0, st;
   logic [4:0] a = 5'h06;
   logic [15:0] wd = 16'h0000, w = 16'h0000, cw, q, pa;
   int mismatches = 0, cmp_count = 0, cyc = 0;
   aes_expansion_status DUT (.CLOCK_I(c), .RST_I(r), .REG_ADDR_I(a),
      .REG_RD_I(rd), .REG_WR_I(wr), .REG_WDATA_I(wd), .CMD_OVERRIDE_I(ov),
      .REG_RDATA_O(q), .PD_FAULT_I(pd), .CODE_WORD_STORE_I(st),
      .CODE_WORD_I(cw), .FLP_VALID_I(fl), .PARTNER_ABILITY_O(pa));
   aes_partner u_lp (.clk_i(c), .send_i(sn), .word_i(w), .store_o(st),
      .word_o(cw));
   initial forever #12.5 c = ~c;
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic rdc(logic [4:0] ad, logic [15:0] e);
      a = ad; rd = 1; @(posedge c); #1 rd = 0; @(posedge c); #1 chk("rd", e, q);
   endtask
   task automatic wrt(logic [15:0] d);
      wd = d;
      wr = 1;
      @(posedge c);
      #1 wr = 0;
      @(posedge c);
      #1;
   endtask
   task automatic send(logic [15:0] d);
      w = d; sn = 1; @(posedge c); #1 sn = 0; @(posedge c); #1;
   endtask
   task automatic complete_run;
      $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge c) if (++cyc > 2000) begin mismatches++; complete_run; end
   initial begin
      repeat (8) @(posedge c);
      #1 r = 0;
      rdc(5'h06, 16'h0004);
      wrt(16'hffe0);
      ov = 1;
      wrt(16'hffe0);
      rdc(5'h06, 16'h0004);
      wrt(16'h0000);
      pd = 1;
      @(posedge c);
      #1 pd = 0;
      rdc(5'h06, 16'h0014);
      rdc(5'h06, 16'h0004);
      send(16'h8000);
      rdc(5'h06, 16'h000e);
      rdc(5'h06, 16'h000c);
      chk("ability", 16'h8000, pa);
      fl = 1;
      send(16'h0001);
      rdc(5'h07, 16'h000c);
      rdc(5'h06, 16'h0007);
      pd = 1;
      @(posedge c);
      #1 pd = 0;
      fl = 0;
      r = 1;
      repeat (2) @(posedge c);
      #1 r = 0;
      chk("ability", 16'h0000, pa);
      chk("rdata", 16'h0000, q);
      rdc(5'h06, 16'h0004);
      complete_run;
   end
endmodule
`default_nettype wire
